/* File: rtl/est_edge_sync.sv */
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none

module est_edge_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level
  input wire logic async_in,
  // Edge pulses
  output logic rise,
  output logic fall
);

  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign rise = stable & ~prev;
  assign fall = ~stable & prev;

endmodule : est_edge_sync

`default_nettype wire

/* File: rtl/est_pkg.sv */
// Types shared by the timer modules
package est_pkg;

  // Clock sources; codes 101 to 111 select no source
  typedef enum logic [2:0] {
    EST_SRC_PIN = 3'b000,
    EST_SRC_PIN_INV = 3'b001,
    EST_SRC_INSTR = 3'b010,
    EST_SRC_SLOW = 3'b011,
    EST_SRC_SYS = 3'b100
  } est_src_type;

  typedef struct packed {
    logic enable;
    logic unused;
    logic out_state;
    logic width_select_bit;
    logic [3:0] post_ratio;
  } est_ctrl_first_type;

  typedef struct packed {
    logic [2:0] clock_source_select;
    logic async_enable_bit;
    logic [3:0] prescale_ratio_field;
  } est_ctrl_second_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } est_bus_req_type;

endpackage : est_pkg

/* File: rtl/est_prescaler.sv */
// Binary prescaler, ratio 1:2^n with n from 0 to 15
`timescale 1ns/1ps
`default_nettype none
`include "est_regs.svh"

module est_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [3:0] ratio,
  // Ticks
  input wire logic tick_in,
  output logic tick_out
);

  logic [`EST_PRESC_W-1:0] cnt;
  logic [`EST_PRESC_W-1:0] mask;

  function automatic logic [`EST_PRESC_W-1:0] ratio_mask(
    input logic [3:0] n);
    ratio_mask = `EST_PRESC_W'((17'h00001 << n) - 17'h00001);
  endfunction : ratio_mask

  assign mask = ratio_mask(ratio);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= '0;
    end else if (tick_in) begin
      cnt <= cnt + `EST_PRESC_W'(1);
    end
  end

  // Ratio zero bypasses the counter entirely
  assign tick_out = tick_in
    && (ratio == 4'h0 || (cnt & mask) == mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_presc_clear_zero:
  assert property (clear |=> cnt == '0)
    else $error("prescaler not cleared");

  chk_presc_bypass_path:
  assert property (ratio == 4'h0 |-> tick_out == tick_in)
    else $error("prescaler bypass broken");

endmodule : est_prescaler

`default_nettype wire

/* File: rtl/est_regs.svh */
// Register offsets, reset values and timing counts of the timer
`ifndef EST_REGS_SVH
`define EST_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define EST_ADDR_W 3
`define EST_OFS_COUNT_LOW 3'h0
`define EST_OFS_COUNT_HIGH 3'h1
`define EST_OFS_CTRL_FIRST 3'h2
`define EST_OFS_CTRL_SECOND 3'h3
`define EST_OFS_IRQ_STATUS 3'h4
`define EST_OFS_IRQ_CLEAR 3'h5
`define EST_OFS_IRQ_ENABLE 3'h6

// ****************************************************************
// Reset values
// ****************************************************************
`define EST_RST_COUNT_LOW 8'h00
`define EST_RST_COUNT_HIGH 8'hFF
`define EST_RST_CTRL 8'h00
`define EST_RST_IRQ 2'h0

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define EST_IRQ_W 2
`define EST_IRQ_PERIOD 0
`define EST_IRQ_WRAP 1
`define EST_PRESC_W 15

// ****************************************************************
// Timing
// ****************************************************************
`define EST_INSTR_DIV 4
`define EST_PHASE_LAST 2'(`EST_INSTR_DIV - 1)

`endif

/* File: rtl/est_timer.sv */
// Eight/sixteen-bit timer-counter with prescaler, postscaler and IRQ
//
// Behaviour
// - Width-select bit of first control register picks 8- or 16-bit
// - 16-bit: high:low count steps per prescaled tick; 15-bit prescaler
// - 16-bit: real high byte hidden; low-byte read copies it into buffer
// - 16-bit: low-byte write loads real high byte from buffer atomically
// - 8-bit: period match pulses output, clears low, reloads period
// - 8-bit: both bytes read/write directly; reset gives low 00, high FF
// - Low-byte write, control write or reset clears both scalers
// - Prescale field zero bypasses prescaler; each source edge adds one
// - Timer mode: one count per instruction cycle, divided by prescaler
// - Async bit set: count on source edges unaligned, also during sleep
// - Async clear: count aligned to instruction clock, rate capped there
// - Three-bit source field of second control register picks source
// - Internal source selected: block counts as a timer of that clock
// - External source selected: block counts rising edges of that clock, falling ones for the inverted pin code
`timescale 1ns/1ps
`default_nettype none
`include "est_regs.svh"

module est_timer
  import est_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // Clock inputs from pins and oscillators
  input wire logic ext_clk_pin,
  input wire logic slow_clk_in,
  // Power state from the same clock domain
  input wire logic sleep_mode,
  // Outputs
  output logic timer_match_output,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  est_bus_req_type req;
  est_ctrl_first_type timer_control_first;
  est_ctrl_second_type timer_control_second;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] high_real;
  logic [7:0] period_buf;
  logic [1:0] phase;
  logic instr_tick, pin_rise, pin_fall, slow_rise, src_tick, pre_tick;
  logic pend, count_tick, mode16, clear_scalers, wr_low, wr_high, rd_low;
  logic at_top, raw_event, post_event;
  logic [3:0] post_cnt;
  logic [`EST_IRQ_W-1:0] irq_status, irq_enable, irq_events;
  logic [`EST_IRQ_W-1:0] irq_clear, next_irq_status, next_irq_enable;

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = 8'(v + 8'h01);
  endfunction : inc8

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic src_select(input logic [2:0] sel,
    input logic p_rise, input logic p_fall, input logic i_tick,
    input logic s_rise);
    case (sel)
      EST_SRC_PIN: src_select = p_rise;
      EST_SRC_PIN_INV: src_select = p_fall;
      EST_SRC_INSTR: src_select = i_tick;
      EST_SRC_SLOW: src_select = s_rise;
      EST_SRC_SYS: src_select = 1'b1;
      default: src_select = 1'b0;
    endcase
  endfunction : src_select

  assign req = '{rd: bus_rd, wr: bus_wr, addr: bus_addr, wdata: bus_wdata};
  assign mode16 = timer_control_first.width_select_bit;
  assign wr_low = req.wr && hit(req.addr, `EST_OFS_COUNT_LOW);
  assign wr_high = req.wr && hit(req.addr, `EST_OFS_COUNT_HIGH);
  assign rd_low = req.rd && hit(req.addr, `EST_OFS_COUNT_LOW);
  assign clear_scalers = wr_low
    || (req.wr && hit(req.addr, `EST_OFS_CTRL_FIRST))
    || (req.wr && hit(req.addr, `EST_OFS_CTRL_SECOND));

  // ****************************************************************
  // Clock sources
  // ****************************************************************
  // The instruction clock halts in sleep; only async counting survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= 2'(phase + 2'h1);
    end
  end

  assign instr_tick = (phase == `EST_PHASE_LAST) && !sleep_mode;

  est_edge_sync u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(ext_clk_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  est_edge_sync u_slow_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(slow_clk_in),
    .rise(slow_rise),
    .fall()
  );

  // Internal codes count as a timer, pin codes as a counter
  assign src_tick = timer_control_first.enable && src_select(
    timer_control_second.clock_source_select, pin_rise, pin_fall,
    instr_tick, slow_rise);

  est_prescaler u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .clear(clear_scalers),
    .ratio(timer_control_second.prescale_ratio_field),
    .tick_in(src_tick),
    .tick_out(pre_tick)
  );

  // ****************************************************************
  // Synchronous alignment
  // ****************************************************************
  // A prescaled edge waits for the next instruction cycle; faster edges
  // in between merge, which is why the rate is capped at that clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (clear_scalers || timer_control_second.async_enable_bit) begin
      pend <= 1'b0;
    end else begin
      pend <= (pend || pre_tick) && !instr_tick;
    end
  end

  assign count_tick = timer_control_second.async_enable_bit ? pre_tick
    : (instr_tick && (pend || pre_tick));

  assign at_top = mode16 ? ({high_real, count_low_byte} == 16'hFFFF)
    : (count_low_byte == period_buf);
  assign raw_event = count_tick && !wr_low && at_top;

  // ****************************************************************
  // Count registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_byte <= `EST_RST_COUNT_LOW;
      high_real <= `EST_RST_COUNT_LOW;
      period_buf <= `EST_RST_COUNT_HIGH;
    end else if (wr_low) begin
      count_low_byte <= req.wdata;
      if (mode16) begin
        high_real <= count_high_byte;
      end
    end else if (count_tick) begin
      if (mode16) begin
        count_low_byte <= inc8(count_low_byte);
        if (count_low_byte == 8'hFF) begin
          high_real <= inc8(high_real);
        end
      end else if (at_top) begin
        count_low_byte <= 8'h00;
        period_buf <= count_high_byte;
      end else begin
        count_low_byte <= inc8(count_low_byte);
      end
    end
  end

  // Buffer in 16-bit mode, period register in 8-bit mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_high_byte <= `EST_RST_COUNT_HIGH;
    end else if (wr_high) begin
      count_high_byte <= req.wdata;
    end else if (rd_low && mode16) begin
      count_high_byte <= high_real;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_first <= `EST_RST_CTRL;
      timer_control_second <= `EST_RST_CTRL;
      irq_enable <= `EST_RST_IRQ;
    end else if (req.wr) begin
      if (hit(req.addr, `EST_OFS_CTRL_FIRST)) begin
        timer_control_first <= req.wdata & 8'hDF;
      end
      if (hit(req.addr, `EST_OFS_CTRL_SECOND)) begin
        timer_control_second <= req.wdata;
      end
      if (hit(req.addr, `EST_OFS_IRQ_ENABLE)) begin
        irq_enable <= req.wdata[`EST_IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Postscaler and output
  // ****************************************************************
  assign post_event = raw_event
    && (post_cnt == timer_control_first.post_ratio);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt <= 4'h0;
    end else if (clear_scalers) begin
      post_cnt <= 4'h0;
    end else if (post_event) begin
      post_cnt <= 4'h0;
    end else if (raw_event) begin
      post_cnt <= 4'(post_cnt + 4'h1);
    end
  end

  // High from the event until the next prescaled tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_match_output <= 1'b0;
    end else if (!timer_control_first.enable) begin
      timer_match_output <= 1'b0;
    end else if (post_event) begin
      timer_match_output <= 1'b1;
    end else if (count_tick) begin
      timer_match_output <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_events = {raw_event && mode16, post_event};
  assign irq_clear = (req.wr && hit(req.addr, `EST_OFS_IRQ_CLEAR))
    ? req.wdata[`EST_IRQ_W-1:0] : `EST_RST_IRQ;
  // Irq follows a same-cycle enable write, so it never lags the mask
  assign next_irq_enable = (req.wr && hit(req.addr, `EST_OFS_IRQ_ENABLE))
    ? req.wdata[`EST_IRQ_W-1:0] : irq_enable;
  // A new event beats a clear landing in the same cycle
  assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `EST_RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & next_irq_enable);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (!req.rd) begin
      bus_rdata <= 8'h00;
    end else begin
      case (req.addr)
        `EST_OFS_COUNT_LOW: bus_rdata <= count_low_byte;
        `EST_OFS_COUNT_HIGH: bus_rdata <= count_high_byte;
        `EST_OFS_CTRL_FIRST: begin
          bus_rdata <= {timer_control_first.enable, 1'b0,
            timer_match_output, timer_control_first[4:0]};
        end
        `EST_OFS_CTRL_SECOND: bus_rdata <= timer_control_second;
        `EST_OFS_IRQ_STATUS: bus_rdata <= 8'(irq_status);
        `EST_OFS_IRQ_ENABLE: bus_rdata <= 8'(irq_enable);
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_low_read16;
    rd_low && mode16;
  endsequence
  sequence s_low_write16;
    wr_low && mode16;
  endsequence
  sequence s_match8;
    count_tick && !mode16 && at_top && !req.wr;
  endsequence
  sequence s_wrap16;
    count_tick && mode16 && at_top && !req.wr;
  endsequence

  chk_hi_buffer_copy:
  assert property (s_low_read16 |=> count_high_byte == $past(high_real))
    else $error("high byte buffer not loaded on low read");
  chk_atomic_write:
  assert property (s_low_write16 |=> high_real == $past(count_high_byte)
    && count_low_byte == $past(req.wdata))
    else $error("16-bit write not atomic");
  chk_match_reload:
  assert property (s_match8 |=> count_low_byte == 8'h00
    && period_buf == $past(count_high_byte))
    else $error("8-bit match did not clear and reload");
  chk_wrap_zero:
  assert property (s_wrap16 |=> {high_real, count_low_byte} == 16'h0000
    && irq_status[`EST_IRQ_WRAP])
    else $error("16-bit wrap lost");
  chk_count_step:
  assert property (count_tick && mode16 && !at_top && !req.wr |=>
    {high_real, count_low_byte} == 16'($past({high_real, count_low_byte})
    + 16'h0001))
    else $error("16-bit count did not advance by one");
  chk_sync_align:
  assert property (count_tick && !timer_control_second.async_enable_bit
    |-> phase == `EST_PHASE_LAST && !sleep_mode)
    else $error("synchronous count off instruction cycle");
  chk_async_sleep:
  assert property (timer_control_second.async_enable_bit && pre_tick
    |-> count_tick)
    else $error("asynchronous tick dropped");
  chk_read_data:
  assert property (req.rd && hit(req.addr, `EST_OFS_COUNT_HIGH)
    |=> bus_rdata == $past(count_high_byte) ##1 bus_rdata == 8'h00
    || $past(req.rd))
    else $error("high byte read data wrong");
  chk_post_clear:
  assert property (clear_scalers |=> post_cnt == 4'h0 && !pend)
    else $error("postscaler not cleared");
  chk_out_hold:
  assert property (timer_match_output && !count_tick
    && timer_control_first.enable |=> timer_match_output)
    else $error("output pulse ended before prescaled period");
  // A clear may follow an event at once, so only an unclear bit must stay
  chk_irq_sticky:
  assert property (irq_events[`EST_IRQ_PERIOD]
    || (irq_status[`EST_IRQ_PERIOD] && !irq_clear[`EST_IRQ_PERIOD])
    |=> irq_status[`EST_IRQ_PERIOD])
    else $error("status bit not sticky");
  chk_irq_level:
  assert property (irq == (|(irq_status & irq_enable)))
    else $error("interrupt level wrong");

endmodule : est_timer

`default_nettype wire

/* File: verification/est_timer_test.sv */
// Register-level self-checking testbench for the eight/sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "est_regs.svh"

module est_timer_test;
  import est_pkg::*;

  // ****************************************************************
  // Clock, reset and design
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic ext_clk_pin = 1'b0;
  logic slow_clk_in = 1'b0;
  logic sleep_mode = 1'b0;
  logic timer_match_output;
  logic irq;
  int failures = 0;
  int n_checks = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  est_timer est_timer_i (
    .clk(clk),
    .rst_n(rst_n),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .ext_clk_pin(ext_clk_pin),
    .slow_clk_in(slow_clk_in),
    .sleep_mode(sleep_mode),
    .timer_match_output(timer_match_output),
    .irq(irq)
  );

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic print_verdict;
    $display("Checks made %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // ****************************************************************
  // Bus access
  // ****************************************************************
  // Each access starts on its own edge, so strobes never re-rise in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(v, e);
  endtask : rdc

  // Irq is registered on the same edge as the status bit; two edges give margin
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [7:0] c2(est_src_type s, logic a, logic [3:0] p);
    return {s, a, p};
  endfunction : c2

  // ****************************************************************
  // Timer helpers
  // ****************************************************************
  task automatic setup(input logic [7:0] c1, input logic [7:0] c,
                       input logic [7:0] hi, input logic [7:0] lo);
    wr(`EST_OFS_CTRL_FIRST, c1 & 8'h7F);
    wr(`EST_OFS_CTRL_SECOND, c);
    wr(`EST_OFS_COUNT_HIGH, hi);
    wr(`EST_OFS_COUNT_LOW, lo);
    wr(`EST_OFS_CTRL_FIRST, c1);
  endtask : setup

  // Pulses are eight clocks apart, slower than the instruction clock
  task automatic pulse(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      {slow_clk_in, ext_clk_pin} <= m;
      repeat (4) @(posedge clk);
      {slow_clk_in, ext_clk_pin} <= 2'b00;
      repeat (3) @(posedge clk);
    end
  endtask : pulse

  task automatic cnt(input logic [7:0] c, input logic [1:0] m,
                     input logic s, input int n, input logic [7:0] e);
    logic [7:0] v;
    setup(8'h90, c, 8'h00, 8'h00);
    sleep_mode <= s;
    pulse(m, n);
    repeat (6) @(posedge clk);
    rd(`EST_OFS_COUNT_LOW, v);
    @(posedge clk);
    sleep_mode <= 1'b0;
    check(v, e);
  endtask : cnt

  // Any 40-clock window holds the same number of periodic ticks
  task automatic rate(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] a;
    logic [7:0] b;
    setup(8'h90, c, 8'h00, 8'h00);
    repeat (20) @(posedge clk);
    rd(`EST_OFS_COUNT_LOW, a);
    repeat (38) @(posedge clk);
    rd(`EST_OFS_COUNT_LOW, b);
    check(8'(b - a), e);
  endtask : rate

  task automatic wait_out(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (timer_match_output !== 1'b1 && c < 300);
    if (c >= 300) begin
      failures++;
      print_verdict();
    end
  endtask : wait_out

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [2:0] ra [7];
    logic [7:0] re [7];
    logic [7:0] v;
    logic seen;
    int c;
    ra = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    re = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdc(ra[i], re[i]);
    end
    wr(`EST_OFS_IRQ_STATUS, 8'hFF);
    rdc(`EST_OFS_IRQ_STATUS, 8'h00);
    // Eight-bit period: first match at FF loads period 3 from high byte
    wr(`EST_OFS_CTRL_SECOND, c2(EST_SRC_SYS, 1'b1, 4'h0));
    wr(`EST_OFS_COUNT_HIGH, 8'h03);
    wr(`EST_OFS_COUNT_LOW, 8'hFF);
    rdc(`EST_OFS_COUNT_HIGH, 8'h03);
    rdc(`EST_OFS_COUNT_LOW, 8'hFF);
    wr(`EST_OFS_CTRL_FIRST, 8'h80);
    wait_out(c);
    wait_out(c);
    check(c, 4);
    @(posedge clk);
    #1;
    check(timer_match_output, 1'b0);
    wait_out(c);
    check(c, 3);
    wr(`EST_OFS_CTRL_FIRST, 8'h00);
    rd(`EST_OFS_IRQ_STATUS, v);
    check(v & 8'h01, 8'h01);
    wr(`EST_OFS_IRQ_CLEAR, 8'h01);
    // Sixteen-bit buffered high byte
    wr(`EST_OFS_CTRL_FIRST, 8'h10);
    wr(`EST_OFS_COUNT_HIGH, 8'h12);
    wr(`EST_OFS_COUNT_LOW, 8'h34);
    rdc(`EST_OFS_COUNT_LOW, 8'h34);
    rdc(`EST_OFS_COUNT_HIGH, 8'h12);
    wr(`EST_OFS_COUNT_HIGH, 8'h56);
    rdc(`EST_OFS_COUNT_HIGH, 8'h56);
    rdc(`EST_OFS_COUNT_LOW, 8'h34);
    rdc(`EST_OFS_COUNT_HIGH, 8'h12);
    // Edge counting by source, sync mode and sleep
    cnt(c2(EST_SRC_PIN, 1'b1, 4'h0), 2'b01, 1'b0, 5, 8'd5);
    cnt(c2(EST_SRC_PIN, 1'b0, 4'h0), 2'b01, 1'b0, 5, 8'd5);
    cnt(c2(EST_SRC_PIN_INV, 1'b1, 4'h0), 2'b01, 1'b0, 3, 8'd3);
    cnt(c2(EST_SRC_SLOW, 1'b1, 4'h0), 2'b10, 1'b0, 4, 8'd4);
    cnt(c2(EST_SRC_PIN, 1'b1, 4'h0), 2'b10, 1'b0, 4, 8'd0);
    cnt(c2(EST_SRC_PIN, 1'b1, 4'h2), 2'b01, 1'b0, 8, 8'd2);
    cnt(c2(EST_SRC_PIN, 1'b1, 4'h0), 2'b01, 1'b1, 5, 8'd5);
    cnt(c2(EST_SRC_PIN, 1'b0, 4'h0), 2'b01, 1'b1, 5, 8'd0);
    // Internal rates over a 40-clock window
    rate(c2(EST_SRC_SYS, 1'b1, 4'h0), 8'd40);
    rate(c2(EST_SRC_SYS, 1'b0, 4'h0), 8'd10);
    rate(c2(EST_SRC_INSTR, 1'b1, 4'h0), 8'd10);
    rate(c2(EST_SRC_SYS, 1'b1, 4'h3), 8'd5);
    rate(8'hB0, 8'h00);
    // Low write restarts the 1:8 prescaler from zero
    setup(8'h90, c2(EST_SRC_SYS, 1'b1, 4'h3), 8'h00, 8'h00);
    repeat (29) @(posedge clk);
    wr(`EST_OFS_COUNT_LOW, 8'h00);
    repeat (18) @(posedge clk);
    rdc(`EST_OFS_COUNT_LOW, 8'h02);
    // Sixteen-bit wrap, interrupt raise, mask and clear
    wr(`EST_OFS_IRQ_ENABLE, 8'h02);
    setup(8'h90, c2(EST_SRC_SYS, 1'b1, 4'h0), 8'hFF, 8'hF0);
    seen = 1'b0;
    c = 0;
    while (irq !== 1'b1 && c < 100) begin
      @(posedge clk);
      #1;
      if (timer_match_output === 1'b1) begin
        seen = 1'b1;
      end
      c++;
    end
    if (c >= 100) begin
      failures++;
      print_verdict();
    end
    check(irq, 1'b1);
    check(seen, 1'b1);
    wr(`EST_OFS_CTRL_FIRST, 8'h10);
    rd(`EST_OFS_COUNT_LOW, v);
    rdc(`EST_OFS_COUNT_HIGH, 8'h00);
    rd(`EST_OFS_IRQ_STATUS, v);
    check(v & 8'h02, 8'h02);
    wr(`EST_OFS_IRQ_ENABLE, 8'h00);
    settle();
    check(irq, 1'b0);
    wr(`EST_OFS_IRQ_ENABLE, 8'h02);
    settle();
    check(irq, 1'b1);
    wr(`EST_OFS_IRQ_CLEAR, 8'h02);
    settle();
    check(irq, 1'b0);
    rd(`EST_OFS_IRQ_STATUS, v);
    check(v & 8'h02, 8'h00);
    print_verdict();
  end

endmodule : est_timer_test
`default_nettype wire
